// ### logic/iox_eight_channel_extension.sv
`timescale 1ns/10ps
// ****************************************
// eight channel i/o extension top
// ****************************************
module iox_eight_channel_extension
  import iox_pkg::*;
#(
  parameter int unsigned WIDTH        = IOX_CHANNELS,
  parameter int unsigned TICK_CYCLES  = IOX_TICK_CYCLES,
  parameter int unsigned FLASH_CYCLES = IOX_FLASH_CYCLES
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // gateway state
  input  wire iox_mode_t        mode_i,
  input  wire logic             debug_mode_i,
  input  wire logic             gateway_start_done_i,
  // selector switches from pins, firmware load done
  input  wire logic             selector_switch_high_i,
  input  wire logic             selector_switch_low_i,
  input  wire logic             firmware_loaded_i,
  // script processor operations
  input  wire iox_cmd_t         cmd_i,
  output logic [7:0]            read_data_o,
  output logic                  read_valid_o,
  output logic                  overload_o,
  output logic                  version_valid_o,
  output logic [7:0]            version_o,
  output logic                  boot_hold_o,
  // field pins
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] overcurrent_i,
  output logic [WIDTH-1:0]      pin_o,
  output logic [WIDTH-1:0]      pin_oe_o,
  // indicator
  output iox_led_t              led_o
);

  initial begin
    if (WIDTH != 8) $error("iox: eight channels only");
    if (TICK_CYCLES < 2 || FLASH_CYCLES < 2) $error("iox: divider too small");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [WIDTH-1:0] pin_s1_q, pin_s2_q;     // field inputs
  logic [WIDTH-1:0] oc_s1_q,  oc_s2_q;      // overcurrent flags
  logic [1:0]       sw_s1_q,  sw_s2_q;      // selector switches

  // two stage capture of everything from the pins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      oc_s1_q  <= '0;
      oc_s2_q  <= '0;
      sw_s1_q  <= '0;
      sw_s2_q  <= '0;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      oc_s1_q  <= overcurrent_i;
      oc_s2_q  <= oc_s1_q;
      sw_s1_q  <= {selector_switch_high_i, selector_switch_low_i};
      sw_s2_q  <= sw_s1_q;
    end
  end

  // ****************************************
  // dividers
  // ****************************************
  logic [31:0] tick_cnt_q;                  // seconds divider
  logic [31:0] flash_cnt_q;                 // flash divider
  logic        tick_q;                      // one pulse per second
  logic        flash_q;                     // one pulse per half flash

  // seconds tick
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // flash tick
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 32'(FLASH_CYCLES - 1)) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b1;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
      flash_q     <= 1'b0;
    end
  end

  // ****************************************
  // boot lock
  // ****************************************
  logic boot_q;                             // held for firmware load

  // both switches in download position latch boot until new firmware
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) boot_q <= 1'b0;
    else if (sw_s2_q == 2'b11) boot_q <= 1'b1;        // [R10]
    else if (firmware_loaded_i) boot_q <= 1'b0;       // [R10]
  end

  // ****************************************
  // operations
  // ****************************************
  logic             cmd_ok;                 // operation accepted
  logic [WIDTH-1:0] mask_q;                 // 1 = output
  logic [WIDTH-1:0] out_q;                  // last written value
  logic             mask_loaded_q;
  logic             used_q;
  logic             test_q;
  logic [7:0]       count_q;                // test counter

  // debug mode and boot hold swallow every operation
  assign cmd_ok = ~debug_mode_i & ~boot_q;                 // [R2]

  // direction mask, one bit per channel
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) mask_q <= IOX_MASK_RST;
    else if (cmd_ok && cmd_i.load_direction_mask) mask_q <= cmd_i.data; // [R1]
  end

  // output value register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) out_q <= IOX_PORT_RST;
    else if (cmd_ok && cmd_i.write_port_outputs) out_q <= cmd_i.data;
  end

  // usage tracking for the indicator; a new mask leaves the flash phase running
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_loaded_q <= 1'b0;
      used_q        <= 1'b0;
    end else if (cmd_ok) begin
      if (cmd_i.load_direction_mask) mask_loaded_q <= 1'b1;   // [R6]
      if (cmd_i.write_port_outputs || cmd_i.read_port_inputs)
        used_q <= 1'b1;                                       // [R5]
    end
  end

  // test counter: starts at zero on entering test mode, one per second
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_q  <= 1'b0;
      count_q <= 8'h00;
    end else begin
      test_q <= (mode_i == IOX_MODE_TEST);
      if (mode_i != IOX_MODE_TEST) count_q <= 8'h00;
      else if (tick_q) count_q <= count_q + 8'h01;            // [R3]
    end
  end

  // read answer merges input pins and output latch
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_data_o  <= '0;
      read_valid_o <= 1'b0;
    end else begin
      read_valid_o <= cmd_ok & cmd_i.read_port_inputs;
      if (cmd_ok && cmd_i.read_port_inputs)
        read_data_o <= (pin_s2_q & ~mask_q) | (out_q & mask_q); // [R14]
    end
  end

  // overload flag: sticky once set, cleared only by reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) overload_o <= 1'b0;
    else if (|(oc_s2_q & mask_q)) overload_o <= 1'b1;        // [R13]
  end

  // pin drivers; test mode drives all channels, lsb on channel one
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else if (test_q) begin
      pin_o    <= count_q;                                   // [R4]
      pin_oe_o <= '1;                                        // [R3]
    end else begin
      pin_o    <= out_q & mask_q;
      pin_oe_o <= mask_q;                                    // [R14]
    end
  end

  // version report, one pulse after gateway start message in config mode
  logic ver_sent_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ver_sent_q      <= 1'b0;
      version_valid_o <= 1'b0;
      version_o       <= '0;
    end else begin
      version_valid_o <= 1'b0;
      version_o       <= IOX_VERSION_ID;
      if (mode_i != IOX_MODE_CONFIG) ver_sent_q <= 1'b0;
      else if (gateway_start_done_i && !ver_sent_q) begin
        ver_sent_q      <= 1'b1;
        version_valid_o <= 1'b1;                             // [R12]
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) boot_hold_o <= 1'b0;
    else       boot_hold_o <= boot_q;
  end

  // ****************************************
  // indicator
  // ****************************************
  iox_led_pattern #(
    .CODE (IOX_ERR_CODE)
  ) u_led (
    .core_clk_i    (core_clk_i),
    .rst_i         (rst_i),
    .flash_en_i    (flash_q),
    .boot_hold_i   (boot_q),                                 // [R11]
    .overload_i    (overload_o),                             // [R9]
    .test_mode_i   (test_q),                                 // [R7]
    .config_mode_i (mode_i == IOX_MODE_CONFIG),              // [R8]
    .mask_loaded_i (mask_loaded_q),
    .port_used_i   (used_q),
    .led_o         (led_o)
  );

endmodule : iox_eight_channel_extension

// ### logic/iox_pkg.sv
// Operation
// R1: eight channels, each direction set by mask
// R2: debug mode ignores every extension operation
// R3: test mode drives counter, increments each second
// R4: channel one is lsb, eight msb
// R5: dark when unused, steady green when used
// R6: flash green after mask, before access
// R7: test mode alternates red and green flashing
// R8: flash red in config mode or error
// R9: overload code twelve: twelve dark blinks, repeat
// R10: download position holds extension in boot
// R11: steady red while held for update
// R12: version message follows gateway start message
// R13: output overcurrent latches readable overload flag
// R14: inputs undriven; read merges pins and outputs
package iox_pkg;

  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int unsigned IOX_CHANNELS    = 8;
  localparam int unsigned IOX_CLK_HZ      = 125_000_000;
  localparam int unsigned IOX_TICK_HZ     = 1;
  localparam int unsigned IOX_TICK_CYCLES = IOX_CLK_HZ / IOX_TICK_HZ;
  localparam int unsigned IOX_FLASH_HZ    = 4;   // flash half period rate
  localparam int unsigned IOX_FLASH_CYCLES = IOX_CLK_HZ / IOX_FLASH_HZ;
  localparam int unsigned IOX_ERR_CODE    = 12;  // overload blink count
  localparam logic [7:0]  IOX_PORT_RST    = 8'h00;
  localparam logic [7:0]  IOX_MASK_RST    = 8'h00; // all inputs after reset
  localparam logic [7:0]  IOX_VERSION_ID  = 8'h01; // arbitrary value

  // ****************************************
  // gateway operating mode
  // ****************************************
  typedef enum logic [1:0] {
    IOX_MODE_RUN,
    IOX_MODE_CONFIG,
    IOX_MODE_TEST
  } iox_mode_t;

  // script processor operation strobes
  typedef struct packed {
    logic       load_direction_mask;
    logic       write_port_outputs;
    logic       read_port_inputs;
    logic [7:0] data;
  } iox_cmd_t;

  // two colour indicator drive
  typedef struct packed {
    logic red;
    logic green;
  } iox_led_t;

endpackage : iox_pkg

// ### logic/iox_led_pattern.sv
`timescale 1ns/10ps
// ****************************************
// indicator pattern generator
// ****************************************
module iox_led_pattern
  import iox_pkg::*;
#(
  parameter int unsigned CODE = IOX_ERR_CODE
) (
  // clock and reset
  input  wire logic     core_clk_i,
  input  wire logic     rst_i,
  // timing
  input  wire logic     flash_en_i,   // one pulse per flash half period
  // state selectors, highest priority first, except port_used_i outranks mask_loaded_i
  input  wire logic     boot_hold_i,
  input  wire logic     overload_i,
  input  wire logic     test_mode_i,
  input  wire logic     config_mode_i,
  input  wire logic     mask_loaded_i,
  input  wire logic     port_used_i,
  // led
  output iox_led_t      led_o
);

  initial begin
    if (CODE < 1 || CODE > 30) $error("iox_led_pattern: CODE out of range");
  end

  logic       phase_q;        // flash phase
  logic       alt_q;          // red/green alternation
  logic [5:0] step_q;         // error sequence step
  iox_led_t   led_d;

  // flash phase toggles every half period
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
      alt_q   <= 1'b0;
    end else if (flash_en_i) begin
      phase_q <= ~phase_q;
      if (phase_q) alt_q <= ~alt_q;
    end
  end

  // error code sequencer: CODE red/dark pairs, so exactly CODE dark gaps per loop;
  // the red step that follows the last gap is step 0, the first red of the next loop
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_q <= 6'h00;
    end else if (!overload_i) begin
      step_q <= 6'h00;
    end else if (flash_en_i) begin
      if (step_q == 6'(2 * CODE - 1)) step_q <= 6'h00;       // [R9]
      else step_q <= step_q + 6'h01;
    end
  end

  // pattern select
  always_comb begin
    led_d = '0;
    if (boot_hold_i) begin
      led_d.red = 1'b1;                         // [R11]
    end else if (overload_i) begin
      led_d.red = ~step_q[0];                   // [R9] odd steps dark
    end else if (test_mode_i) begin
      led_d.red   = phase_q & alt_q;            // [R7]
      led_d.green = phase_q & ~alt_q;
    end else if (config_mode_i) begin
      led_d.red = phase_q;                      // [R8]
    end else if (port_used_i) begin
      led_d.green = 1'b1;                       // [R5]
    end else if (mask_loaded_i) begin
      led_d.green = phase_q;                    // [R6]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) led_o <= '0;
    else       led_o <= led_d;
  end

endmodule : iox_led_pattern

// ### sim/iox_properties.sv
`timescale 1ns/10ps
// ********
// port checker
// ********
module iox_properties
  import iox_pkg::*;
#(
  parameter int unsigned WIDTH       = 8,
  parameter int unsigned TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  // gateway side
  input wire iox_mode_t        mode_i,
  input wire logic             debug_mode_i,
  input wire logic             gateway_start_done_i,
  input wire iox_cmd_t         cmd_i,
  input wire logic             read_valid_o,
  input wire logic             overload_o,
  input wire logic             version_valid_o,
  input wire logic [7:0]       version_o,
  input wire logic             boot_hold_o,
  input wire iox_led_t         led_o,
  // field side
  input wire logic [WIDTH-1:0] overcurrent_i,
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pin_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire ok_w  = !debug_mode_i && !boot_hold_o && mode_i != IOX_MODE_TEST; // strobe is taken and shows on the pins (not in test mode)
  wire tst_w = mode_i == IOX_MODE_TEST;
  // cmd_i[10:9] are the mask and write strobes; a quiet follower keeps the walk simple
  sequence s_wr;
    ok_w && cmd_i.write_port_outputs && !cmd_i.load_direction_mask ##1 cmd_i[10:9] == 2'b00;
  endsequence
  sequence s_mask;
    ok_w && cmd_i.load_direction_mask && !cmd_i.write_port_outputs ##1 cmd_i[10:9] == 2'b00;
  endsequence
  // counter step spacing; armed only after a +1 step so entry jumps are skipped
  logic [WIDTH-1:0] prev_q;
  logic [31:0]      gap_q;
  logic             armed_q;
  wire chg_w = pin_o != prev_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q  <= '0;
      gap_q   <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= pin_o;
      gap_q   <= chg_w ? 32'h0 : gap_q + 32'h1;
      armed_q <= tst_w && (armed_q || (chg_w && pin_o == prev_q + 1'b1));
    end
  end
  AST_READ_ANSWER: assert property (
    cmd_i.read_port_inputs && !debug_mode_i && !boot_hold_o |=> read_valid_o)
    else $error("read strobe not answered");
  AST_DEBUG_IGNORE: assert property (
    debug_mode_i && cmd_i.read_port_inputs |=> !read_valid_o)
    else $error("read answered in debug mode");
  AST_WRITE_PINS: assert property (
    s_wr |=> pin_o == ($past(cmd_i.data, 2) & pin_oe_o))
    else $error("written value not on driven pins");
  AST_MASK_OE: assert property (
    s_mask |=> pin_oe_o == $past(cmd_i.data, 2))
    else $error("direction mask not applied");
  AST_TEST_STEP: assert property (
    tst_w [*6] ##0 chg_w |-> pin_o == prev_q + 1'b1)
    else $error("test counter did not step by one");
  AST_TEST_TICK: assert property (
    armed_q && tst_w && chg_w |-> gap_q == TICK_CYCLES - 1)
    else $error("test counter step spacing wrong");
  AST_OVERLOAD: assert property (
    |(overcurrent_i & pin_oe_o) && !tst_w |-> ##[1:3] overload_o)
    else $error("overload not flagged");
  AST_OVERLOAD_HOLD: assert property (
    overload_o |=> overload_o)
    else $error("overload flag dropped");
  AST_BOOT_RED: assert property (
    boot_hold_o [*2] |-> led_o.red && !led_o.green)
    else $error("indicator not steady red in boot hold");
  AST_VERSION: assert property (
    version_valid_o |-> $past(gateway_start_done_i) && $past(mode_i) == IOX_MODE_CONFIG
      && version_o == IOX_VERSION_ID)
    else $error("version report out of place");
endmodule : iox_properties

bind iox_eight_channel_extension iox_properties #(
  .WIDTH(WIDTH), .TICK_CYCLES(TICK_CYCLES)) i_iox_properties (.*);

// ### sim/iox_field_model.sv
`timescale 1ns/10ps
// ********
// field side: sensors and loads
// ********
module iox_field_model (
  // from the extension
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  // scenario controls
  input  wire logic [7:0] sense_i,   // sensor levels on undriven channels
  input  wire logic [7:0] short_i,   // current sense trips, as commanded
  // to the extension
  output logic      [7:0] pin_i,
  output logic      [7:0] overcurrent_i
);
  // driven channels read back their own level, others see the sensor
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & sense_i);
  // trips passed as is, so a trip on an input channel can be staged
  assign overcurrent_i = short_i;
endmodule : iox_field_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import iox_pkg::*;
;
  // ********
  // stimulus and design
  // ********
  localparam int TICK = 20;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  iox_mode_t  mode_i = IOX_MODE_RUN;
  logic       dbg = 1'b0, start = 1'b0, sw_hi = 1'b0, sw_lo = 1'b0, fw_ld = 1'b0;
  iox_cmd_t   cmd_i = '0;
  logic [7:0] sense = 8'h00, short = 8'h00;
  logic [7:0] rd_data, version, pin_i, oc, pin_o, pin_oe;
  logic       rd_vld, ovl, ver_vld, boot;
  iox_led_t   led;
  int         seed = 25351, n_fail = 0, comparisons = 0;
  always #4 core_clk_i = ~core_clk_i;
  iox_eight_channel_extension #(.TICK_CYCLES(TICK), .FLASH_CYCLES(4))
    i_iox_eight_channel_extension (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mode_i(mode_i), .debug_mode_i(dbg),
    .gateway_start_done_i(start), .selector_switch_high_i(sw_hi),
    .selector_switch_low_i(sw_lo), .firmware_loaded_i(fw_ld), .cmd_i(cmd_i),
    .read_data_o(rd_data), .read_valid_o(rd_vld), .overload_o(ovl),
    .version_valid_o(ver_vld), .version_o(version), .boot_hold_o(boot),
    .pin_i(pin_i), .overcurrent_i(oc), .pin_o(pin_o), .pin_oe_o(pin_oe), .led_o(led));
  iox_field_model i_iox_field_model (.pin_o(pin_o), .pin_oe_o(pin_oe), .sense_i(sense),
    .short_i(short), .pin_i(pin_i), .overcurrent_i(oc));
  // ********
  // helpers
  // ********
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // one strobe cycle; {mask, write, read}
  task op(input logic [2:0] lwr, input logic [7:0] d);
    cmd_i = {lwr, d};
    cyc(1);
    cmd_i = '0;
  endtask : op
  // indicator levels seen: {red on, red off, green on, green off}
  task leds(output logic [7:0] s);
    s = 8'h00;
    repeat (48) begin
      cyc(1);
      s[3:0] = s[3:0] | {led.red, !led.red, led.green, !led.green};
    end
  endtask : leds
  function automatic logic [7:0] exp_rd(logic [7:0] m, logic [7:0] d, logic [7:0] f);
    return (f & ~m) | (d & m);
  endfunction : exp_rd
  // ********
  // scenarios
  // ********
  initial begin
    logic [7:0] m, d, v, s, n;
    logic       r;
    cyc(2);
    rst_i = 1'b0;
    cyc(1);
    leds(s); chk(s, 8'h05);
    chk(pin_oe, 8'h00);
    m = $random(seed);
    op(3'b100, m);
    cyc(1);
    chk(pin_oe, m);
    leds(s); chk(s, 8'h07);
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      sense = $random(seed);
      op(3'b010, d);
      cyc(1);
      chk(pin_o, d & m);
      cyc(2);
      op(3'b001, 8'h00);
      chk({7'h0, rd_vld}, 8'h01);
      chk(rd_data, exp_rd(m, d, sense));
    end
    leds(s); chk(s, 8'h06);
    op(3'b110, 8'h3c); // mask and write in one strobe
    cyc(1);
    chk(pin_oe, 8'h3c);
    chk(pin_o, 8'h3c);
    dbg = 1'b1;
    op(3'b110, 8'hc3);
    cyc(1);
    op(3'b001, 8'h00);
    chk({7'h0, rd_vld}, 8'h00);
    chk(pin_oe, 8'h3c);
    dbg = 1'b0;
    short = 8'h01; // trip on an input channel
    cyc(4);
    chk({7'h0, ovl}, 8'h00);
    short = 8'h04;
    cyc(4);
    short = 8'h00;
    leds(s); chk(s, 8'h0d);
    // one full code loop is two flash ticks per blink: count the dark gaps in it
    n = 8'h00;
    repeat (4 * 2 * IOX_ERR_CODE) begin
      r = led.red;
      cyc(1);
      n = n + {7'h0, r & !led.red};
    end
    chk(n, 8'(IOX_ERR_CODE));
    cyc(40);
    chk({7'h0, ovl}, 8'h01);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    mode_i = IOX_MODE_TEST;
    cyc(2 * TICK + 5);
    chk(pin_oe, 8'hff);
    v = pin_o;
    cyc(TICK);
    chk(pin_o, v + 8'h01);
    leds(s); chk(s, 8'h0f);
    mode_i = IOX_MODE_CONFIG;
    cyc(2);
    leds(s); chk(s, 8'h0d);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    for (int i = 0; i < 4 && ver_vld !== 1'b1; i++) cyc(1);
    chk({7'h0, ver_vld}, 8'h01);
    chk(version, IOX_VERSION_ID);
    mode_i = IOX_MODE_RUN;
    sw_hi = 1'b1; // one switch alone is not the download position
    cyc(6);
    chk({7'h0, boot}, 8'h00);
    sw_lo = 1'b1;
    for (int i = 0; i < 8 && boot !== 1'b1; i++) cyc(1);
    sw_hi = 1'b0;
    sw_lo = 1'b0;
    cyc(4);
    chk({7'h0, boot}, 8'h01);
    op(3'b001, 8'h00);
    chk({7'h0, rd_vld}, 8'h00);
    leds(s); chk(s, 8'h09);
    fw_ld = 1'b1;
    cyc(1);
    fw_ld = 1'b0;
    cyc(3);
    chk({7'h0, boot}, 8'h00);
    print_verdict;
  end
  // hang guard, well past the expected run length
  initial begin
    repeat (4000) @(posedge core_clk_i);
    n_fail++;
    print_verdict;
  end
endmodule : tb_top
